//--- hdl/icc_pkg.sv
package icc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [31:0] ICC_PREVIEW_SIZE_OFS     = 32'hfffc_0020;
    localparam logic [31:0] ICC_PREVIEW_DECIM_OFS    = 32'hfffc_0024;
    localparam logic [31:0] ICC_PREVIEW_DESC_OFS     = 32'hfffc_0028;
    localparam logic [31:0] ICC_CODEC_BASE_OFS       = 32'hfffc_002c;
    localparam logic [31:0] ICC_Y2R_A_OFS            = 32'hfffc_0030;
    localparam logic [31:0] ICC_Y2R_B_OFS            = 32'hfffc_0034;
    localparam logic [31:0] ICC_R2Y_A_OFS            = 32'hfffc_0038;
    localparam logic [31:0] ICC_R2Y_B_OFS            = 32'hfffc_003c;
    localparam logic [31:0] ICC_R2Y_C_OFS            = 32'hfffc_0040;
    localparam logic [31:0] ICC_FORMAT_OFS           = 32'hfffc_0044;
    localparam logic [31:0] ICC_DESC_PTR_OFS         = 32'hfffc_0048;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] ICC_PREVIEW_SIZE_RST     = 32'h0000_0000;
    localparam logic [31:0] ICC_PREVIEW_DECIM_RST    = 32'h0000_0010;
    localparam logic [31:0] ICC_PREVIEW_DESC_RST     = 32'h0000_0000;
    localparam logic [31:0] ICC_CODEC_BASE_RST       = 32'h0000_0000;
    localparam logic [31:0] ICC_Y2R_A_RST            = 32'h6832_cc95;
    localparam logic [31:0] ICC_Y2R_B_RST            = 32'h0000_7102;
    localparam logic [31:0] ICC_R2Y_A_RST            = 32'h0132_4145;
    localparam logic [31:0] ICC_R2Y_B_RST            = 32'h0124_5e38;
    localparam logic [31:0] ICC_R2Y_C_RST            = 32'h0138_4a4b;

    // ------------------------------------------------------------------
    // Field positions and limits
    // ------------------------------------------------------------------
    localparam int          ICC_VSIZE_LSB            = 0;
    localparam int          ICC_HSIZE_LSB            = 16;
    localparam logic [31:0] ICC_PREVIEW_SIZE_MASK    = 32'h03ff_03ff;
    localparam logic [31:0] ICC_DECIM_MASK           = 32'h0000_00ff;
    localparam logic [31:0] ICC_WORD_ALIGN_MASK      = 32'hffff_fffc;
    localparam logic [31:0] ICC_Y2R_B_MASK           = 32'h0000_71ff;
    localparam logic [31:0] ICC_R2Y_MASK             = 32'h01ff_ffff;
    localparam int          ICC_Y2R_YOFF_BIT         = 12;
    localparam int          ICC_Y2R_CROFF_BIT        = 13;
    localparam int          ICC_Y2R_CBOFF_BIT        = 14;
    localparam int          ICC_R2Y_OFF_BIT          = 24;
    localparam logic [10:0] ICC_VSIZE_RGB_MAX        = 11'h01e0;
    localparam logic [10:0] ICC_HSIZE_RGB_MAX        = 11'h0280;
    localparam logic [7:0]  ICC_DECIM_MIN            = 8'h10;
    localparam logic [9:0]  ICC_YOFF_VALUE           = 10'h080;
    localparam logic [9:0]  ICC_CROFF_VALUE          = 10'h010;
    localparam logic [9:0]  ICC_CBOFF_VALUE          = 10'h010;
    localparam logic [9:0]  ICC_RGB_OFF_VALUE        = 10'h010;
    localparam int          ICC_STEP128_SHIFT        = 7;
    localparam int          ICC_STEP256_SHIFT        = 8;
    localparam int          ICC_STEP512_SHIFT        = 9;

    typedef struct packed {
        logic [7:0] c0;
        logic [7:0] c1;
        logic [7:0] c2;
    } icc_pixel_type;

endpackage : icc_pkg

//--- hdl/icc_matrix.sv
`timescale 1ns/1ps
`default_nettype none

// Three-output colour matrix: out_k = clip(sum((in_j * coef) >> shift) + offset).
// Each coefficient has its own shift, so mixed 1/128, 1/256, 1/512 steps share one datapath.
module icc_matrix (
    input  wire logic                   mclk,       // System clock.
    input  wire logic                   rst,        // Asynchronous reset.
    input  wire icc_pkg::icc_pixel_type pix_in,     // Input components.
    input  wire logic [80:0]            coef,       // Nine 9-bit coefficients.
    input  wire logic [35:0]            shift,      // Nine 4-bit shifts.
    input  wire logic [29:0]            offs,       // Three 10-bit offsets.
    output icc_pkg::icc_pixel_type      pix_out     // Clipped outputs.
);
    import icc_pkg::*;

    logic [7:0] comp [3];
    logic [7:0] res  [3];

    assign comp[0] = pix_in.c0;
    assign comp[1] = pix_in.c1;
    assign comp[2] = pix_in.c2;

    genvar k;
    generate
        for (k = 0; k < 3; k = k + 1) begin : g_out
            logic [19:0] sum;
            always_comb begin
                sum = 20'h0_0000;
                for (int j = 0; j < 3; j++) begin
                    sum = sum + 20'((18'(comp[j]) * 18'(coef[(k*3+j)*9 +: 9]))
                                    >> shift[(k*3+j)*4 +: 4]);
                end
                sum = sum + 20'(offs[k*10 +: 10]);
                res[k] = (sum > 20'h0_00ff) ? 8'hff : sum[7:0];
            end
        end
    endgenerate

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pix_out <= '0;
        end else begin
            pix_out <= '{c0: res[0], c1: res[1], c2: res[2]};
        end
    end

endmodule // icc_matrix

`default_nettype wire

//--- hdl/icc_config.sv
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module icc_config (
    input  wire logic                   mclk,            // 200 MHz system clock.
    input  wire logic                   rst,             // Asynchronous reset, active high.
    input  wire logic [31:0]            addr,            // Register byte address.
    input  wire logic [31:0]            wdata,           // Write data.
    input  wire logic                   wr,              // Write strobe.
    input  wire logic                   rd,              // Read strobe.
    output logic [31:0]                 rdata,           // Read data, cycle after rd.
    input  wire logic                   desc_load,       // Datapath advances descriptor.
    input  wire logic [31:0]            desc_next,       // Next descriptor pointer.
    input  wire icc_pkg::icc_pixel_type yuv_in,          // YCrCb pixel in (Y, Cr, Cb).
    input  wire icc_pkg::icc_pixel_type rgb_in,          // RGB pixel in (R, G, B).
    output icc_pkg::icc_pixel_type      rgb_out,         // Converted RGB pixel.
    output icc_pkg::icc_pixel_type      yuv_out,         // Converted YCrCb pixel.
    output logic [10:0]                 preview_height,  // Effective preview lines.
    output logic [10:0]                 preview_width,   // Effective preview pixels.
    output logic [7:0]                  preview_decimation_ratio, // Effective ratio.
    output logic                        decimation_on,   // Decimation active.
    output logic [31:0]                 preview_descriptor_pointer, // Pointer in use.
    output logic [31:0]                 codec_base       // Codec buffer start.
);
    import icc_pkg::*;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [31:0] preview_size;
    logic [31:0] preview_decimation;
    logic [31:0] preview_descriptor_base;
    logic [31:0] desc_ptr;
    logic [31:0] codec_buffer_base;
    logic [31:0] yuv_to_rgb_coeffs_a;
    logic [31:0] yuv_to_rgb_coeffs_b;
    logic [31:0] rgb_to_yuv_coeffs_a;
    logic [31:0] rgb_to_yuv_coeffs_b;
    logic [31:0] rgb_to_yuv_coeffs_c;
    logic        rgb_mode;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            preview_size            <= ICC_PREVIEW_SIZE_RST;
            preview_decimation      <= ICC_PREVIEW_DECIM_RST;
            codec_buffer_base       <= ICC_CODEC_BASE_RST;
            yuv_to_rgb_coeffs_a     <= ICC_Y2R_A_RST;
            yuv_to_rgb_coeffs_b     <= ICC_Y2R_B_RST;
            rgb_to_yuv_coeffs_a     <= ICC_R2Y_A_RST;
            rgb_to_yuv_coeffs_b     <= ICC_R2Y_B_RST;
            rgb_to_yuv_coeffs_c     <= ICC_R2Y_C_RST;
            rgb_mode                <= 1'b0;
        end else if (wr) begin
            case (addr)
                ICC_PREVIEW_SIZE_OFS:  preview_size <= wdata & ICC_PREVIEW_SIZE_MASK;
                ICC_PREVIEW_DECIM_OFS: preview_decimation <= wdata & ICC_DECIM_MASK;
                ICC_CODEC_BASE_OFS:    codec_buffer_base <= wdata;
                ICC_Y2R_A_OFS:         yuv_to_rgb_coeffs_a <= wdata;
                ICC_Y2R_B_OFS:         yuv_to_rgb_coeffs_b <= wdata & ICC_Y2R_B_MASK;
                ICC_R2Y_A_OFS:         rgb_to_yuv_coeffs_a <= wdata & ICC_R2Y_MASK;
                ICC_R2Y_B_OFS:         rgb_to_yuv_coeffs_b <= wdata & ICC_R2Y_MASK;
                ICC_R2Y_C_OFS:         rgb_to_yuv_coeffs_c <= wdata & ICC_R2Y_MASK;
                ICC_FORMAT_OFS:        rgb_mode <= wdata[0];
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Descriptor: written base restarts the pointer, datapath advances it
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            preview_descriptor_base <= ICC_PREVIEW_DESC_RST;
            desc_ptr                <= ICC_PREVIEW_DESC_RST;
        end else if (wr && addr == ICC_PREVIEW_DESC_OFS) begin
            preview_descriptor_base <= wdata & ICC_WORD_ALIGN_MASK;
            desc_ptr                <= wdata & ICC_WORD_ALIGN_MASK;
        end else if (desc_load) begin
            desc_ptr <= desc_next & ICC_WORD_ALIGN_MASK;
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else if (rd) begin
            case (addr)
                ICC_PREVIEW_SIZE_OFS:  rdata <= preview_size;
                ICC_PREVIEW_DECIM_OFS: rdata <= preview_decimation;
                ICC_PREVIEW_DESC_OFS:  rdata <= desc_ptr;
                ICC_CODEC_BASE_OFS:    rdata <= codec_buffer_base;
                ICC_Y2R_A_OFS:         rdata <= yuv_to_rgb_coeffs_a;
                ICC_Y2R_B_OFS:         rdata <= yuv_to_rgb_coeffs_b;
                ICC_R2Y_A_OFS:         rdata <= rgb_to_yuv_coeffs_a;
                ICC_R2Y_B_OFS:         rdata <= rgb_to_yuv_coeffs_b;
                ICC_R2Y_C_OFS:         rdata <= rgb_to_yuv_coeffs_c;
                ICC_FORMAT_OFS:        rdata <= {31'h0000_0000, rgb_mode};
                ICC_DESC_PTR_OFS:      rdata <= preview_descriptor_base;
                default:               rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Effective preview geometry and decimation
    // ------------------------------------------------------------------
    logic [10:0] next_height;
    logic [10:0] next_width;

    always_comb begin
        next_height = 11'(preview_size[ICC_VSIZE_LSB +: 10]) + 11'h001;
        next_width  = 11'(preview_size[ICC_HSIZE_LSB +: 10]) + 11'h001;
        // The cap is applied only for RGB; YCrCb previews may exceed it.
        if (rgb_mode && next_height > ICC_VSIZE_RGB_MAX) begin
            next_height = ICC_VSIZE_RGB_MAX;
        end
        if (rgb_mode && next_width > ICC_HSIZE_RGB_MAX) begin
            next_width = ICC_HSIZE_RGB_MAX;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            preview_height             <= 11'h001;
            preview_width              <= 11'h001;
            preview_decimation_ratio   <= ICC_DECIM_MIN;
            decimation_on              <= 1'b0;
            preview_descriptor_pointer <= ICC_PREVIEW_DESC_RST;
            codec_base                 <= ICC_CODEC_BASE_RST;
        end else begin
            preview_height <= next_height;
            preview_width  <= next_width;
            // Ratios up to 16 are a pass-through, so the output is clamped to 16.
            decimation_on  <= preview_decimation[7:0] > ICC_DECIM_MIN;
            preview_decimation_ratio <= (preview_decimation[7:0] > ICC_DECIM_MIN) ?
                                        preview_decimation[7:0] : ICC_DECIM_MIN;
            preview_descriptor_pointer <= desc_ptr;
            codec_base     <= codec_buffer_base;
        end
    end

    // ------------------------------------------------------------------
    // YCrCb to RGB: R = Y*C0 + Cr*C1, G = Y*C0 - not modelled signed;
    // all coefficients are unsigned magnitudes on a 1/128 grid.
    // ------------------------------------------------------------------
    logic [80:0] y2r_coef;
    logic [35:0] y2r_shift;
    logic [29:0] y2r_offs;
    logic [9:0]  y_off;
    logic [9:0]  cr_off;
    logic [9:0]  cb_off;

    always_comb begin
        y_off  = yuv_to_rgb_coeffs_b[ICC_Y2R_YOFF_BIT]  ? ICC_YOFF_VALUE  : 10'h000;
        cr_off = yuv_to_rgb_coeffs_b[ICC_Y2R_CROFF_BIT] ? ICC_CROFF_VALUE : 10'h000;
        cb_off = yuv_to_rgb_coeffs_b[ICC_Y2R_CBOFF_BIT] ? ICC_CBOFF_VALUE : 10'h000;
        // Rows: R = C0*Y + C1*Cr; G = C0*Y + C2*Cr + C3*Cb; B = C0*Y + C4*Cb.
        y2r_coef = {
            9'(yuv_to_rgb_coeffs_b[8:0]), 9'h000, 9'(yuv_to_rgb_coeffs_a[7:0]),
            9'(yuv_to_rgb_coeffs_a[31:24]), 9'(yuv_to_rgb_coeffs_a[23:16]),
            9'(yuv_to_rgb_coeffs_a[7:0]),
            9'h000, 9'(yuv_to_rgb_coeffs_a[15:8]), 9'(yuv_to_rgb_coeffs_a[7:0])
        };
        y2r_shift = {9{4'(ICC_STEP128_SHIFT)}};
        y2r_offs  = {10'(y_off + cb_off), 10'(y_off + cr_off + cb_off), 10'(y_off + cr_off)};
    end

    icc_matrix u_y2r (
        .mclk    (mclk),
        .rst     (rst),
        .pix_in  (yuv_in),
        .coef    (y2r_coef),
        .shift   (y2r_shift),
        .offs    (y2r_offs),
        .pix_out (rgb_out)
    );

    // ------------------------------------------------------------------
    // RGB to YCrCb: rows A, B, C have steps 1/256-1/128-1/512, 1/128-1/256-1/512, 1/512-1/256-1/128.
    // ------------------------------------------------------------------
    logic [80:0] r2y_coef;
    logic [35:0] r2y_shift;
    logic [29:0] r2y_offs;
    logic [9:0]  r_off;
    logic [9:0]  g_off;
    logic [9:0]  b_off;

    always_comb begin
        // Each set's offset bit lifts only the output that the same set produces.
        r_off = rgb_to_yuv_coeffs_a[ICC_R2Y_OFF_BIT] ? ICC_RGB_OFF_VALUE : 10'h000;
        g_off = rgb_to_yuv_coeffs_b[ICC_R2Y_OFF_BIT] ? ICC_RGB_OFF_VALUE : 10'h000;
        b_off = rgb_to_yuv_coeffs_c[ICC_R2Y_OFF_BIT] ? ICC_RGB_OFF_VALUE : 10'h000;
        r2y_coef = {
            9'(rgb_to_yuv_coeffs_c[23:16]), 9'(rgb_to_yuv_coeffs_c[15:8]),
            9'(rgb_to_yuv_coeffs_c[7:0]),
            9'(rgb_to_yuv_coeffs_b[23:16]), 9'(rgb_to_yuv_coeffs_b[15:8]),
            9'(rgb_to_yuv_coeffs_b[7:0]),
            9'(rgb_to_yuv_coeffs_a[23:16]), 9'(rgb_to_yuv_coeffs_a[15:8]),
            9'(rgb_to_yuv_coeffs_a[7:0])
        };
        r2y_shift = {
            4'(ICC_STEP128_SHIFT), 4'(ICC_STEP256_SHIFT), 4'(ICC_STEP512_SHIFT),
            4'(ICC_STEP512_SHIFT), 4'(ICC_STEP256_SHIFT), 4'(ICC_STEP128_SHIFT),
            4'(ICC_STEP512_SHIFT), 4'(ICC_STEP128_SHIFT), 4'(ICC_STEP256_SHIFT)
        };
        r2y_offs = {b_off, g_off, r_off};
    end

    icc_matrix u_r2y (
        .mclk    (mclk),
        .rst     (rst),
        .pix_in  (rgb_in),
        .coef    (r2y_coef),
        .shift   (r2y_shift),
        .offs    (r2y_offs),
        .pix_out (yuv_out)
    );

endmodule // icc_config

`default_nettype wire

//--- tb/icc_config_chk.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Port-level checks of the configuration bank
// ----------------------------------------------------------------------
module icc_config_chk
    import icc_pkg::*;
(
    input wire logic        mclk,                       // Clock.
    input wire logic        rst,                        // Reset.
    input wire logic [31:0] addr,                       // Address.
    input wire logic [31:0] wdata,                      // Write data.
    input wire logic        wr,                         // Write strobe.
    input wire logic        rd,                         // Read strobe.
    input wire logic [31:0] rdata,                      // Read data.
    input wire logic        desc_load,                  // Pointer advance.
    input wire logic [31:0] desc_next,                  // Next pointer.
    input wire logic [10:0] preview_height,             // Lines.
    input wire logic [10:0] preview_width,              // Pixels.
    input wire logic [7:0]  preview_decimation_ratio,   // Ratio.
    input wire logic        decimation_on,              // Ratio active.
    input wire logic [31:0] preview_descriptor_pointer, // Pointer in use.
    input wire logic [31:0] codec_base                  // Codec start.
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // Derived outputs trail the write by two edges, so keep the data that long.
    logic [31:0] wd1;
    logic [31:0] wd2;

    always_ff @(posedge mclk) begin
        wd1 <= wdata;
        wd2 <= wd1;
    end

    rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data not zero outside a read");
    ratio_write_a: assert property (wr && addr == ICC_PREVIEW_DECIM_OFS |-> ##2
        preview_decimation_ratio == ((wd2[7:0] < 8'h10) ? 8'h10 : wd2[7:0]))
        else $error("decimation ratio wrong after write");
    ratio_flag_a: assert property (
        decimation_on == (preview_decimation_ratio > 8'h10))
        else $error("decimation flag disagrees with ratio");
    height_plus_a: assert property (wr && addr == ICC_PREVIEW_SIZE_OFS &&
        wdata[9:0] < 10'd480 |-> ##2 preview_height == {1'b0, wd2[9:0]} + 11'd1)
        else $error("preview height is not field plus one");
    height_range_a: assert property (preview_height inside {[11'd1:11'd1024]})
        else $error("preview height out of range");
    width_range_a: assert property (preview_width inside {[11'd1:11'd1024]})
        else $error("preview width out of range");
    desc_align_a: assert property (preview_descriptor_pointer[1:0] == 2'b00)
        else $error("descriptor pointer not word aligned");
    desc_read_a: assert property (rd && addr == ICC_PREVIEW_DESC_OFS
        |=> rdata[1:0] == 2'b00)
        else $error("descriptor read not word aligned");
    desc_advance_a: assert property (desc_load &&
        !(wr && addr == ICC_PREVIEW_DESC_OFS)
        |-> ##2 preview_descriptor_pointer == ($past(desc_next, 2) & ICC_WORD_ALIGN_MASK))
        else $error("descriptor pointer did not advance");
    codec_hold_a: assert property (wr && addr == ICC_CODEC_BASE_OFS
        |-> ##2 codec_base == wd2)
        else $error("codec base not taken from write");
endmodule // icc_config_chk

`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import icc_pkg::*;

    logic          mclk;
    logic          rst;
    logic [31:0]   addr;
    logic [31:0]   wdata;
    logic          wr;
    logic          rd;
    logic [31:0]   rdata;
    logic          desc_load;
    logic [31:0]   desc_next;
    icc_pixel_type yuv_in;
    icc_pixel_type rgb_in;
    icc_pixel_type rgb_out;
    icc_pixel_type yuv_out;
    logic [10:0]   preview_height;
    logic [10:0]   preview_width;
    logic [7:0]    preview_decimation_ratio;
    logic          decimation_on;
    logic [31:0]   preview_descriptor_pointer;
    logic [31:0]   codec_base;
    int            mismatches;
    int            tests_run;

    localparam logic [31:0] RA [10] = '{ICC_PREVIEW_SIZE_OFS, ICC_PREVIEW_DECIM_OFS,
        ICC_PREVIEW_DESC_OFS, ICC_CODEC_BASE_OFS, ICC_Y2R_A_OFS, ICC_Y2R_B_OFS,
        ICC_R2Y_A_OFS, ICC_R2Y_B_OFS, ICC_R2Y_C_OFS, ICC_FORMAT_OFS};
    localparam logic [31:0] RR [10] = '{32'h0, 32'h0000_0010, 32'h0, 32'h0, 32'h6832_cc95,
        32'h0000_7102, 32'h0132_4145, 32'h0124_5e38, 32'h0138_4a4b, 32'h0};
    localparam logic [31:0] R1 [10] = '{32'h03ff_03ff, 32'h0000_00ff, 32'hffff_fffc,
        32'hffff_ffff, 32'hffff_ffff, 32'h0000_71ff, 32'h01ff_ffff, 32'h01ff_ffff,
        32'h01ff_ffff, 32'h0000_0001};
    localparam logic [7:0]  DF [4] = '{8'h05, 8'h10, 8'h11, 8'hff};
    localparam logic [7:0]  DR [4] = '{8'h10, 8'h10, 8'h11, 8'hff};
    localparam logic [31:0] CA [4] = '{32'h0000_00ff, 32'h0000_8000, 32'h00ff_0000,
        32'h0100_0000};
    localparam logic [23:0] CY [4] = '{24'hc7_0000, 24'h4d_0000, 24'h7f_0000, 24'h10_0000};

    icc_config dut (
        .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .desc_load(desc_load), .desc_next(desc_next),
        .yuv_in(yuv_in), .rgb_in(rgb_in), .rgb_out(rgb_out), .yuv_out(yuv_out),
        .preview_height(preview_height), .preview_width(preview_width),
        .preview_decimation_ratio(preview_decimation_ratio),
        .decimation_on(decimation_on),
        .preview_descriptor_pointer(preview_descriptor_pointer),
        .codec_base(codec_base)
    );

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask

    task automatic settle();
        repeat (3) @(posedge mclk);
        #1;
    endtask

    task automatic results();
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // The whole sequence needs well under a thousand cycles.
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        $display("[ERR] %0t watchdog expired", $time);
        results();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        mismatches = 0;
        tests_run = 0;
        {rst, addr, wdata, wr, rd, desc_load, desc_next} = {1'b1, 99'h0};
        yuv_in = '0;
        rgb_in = '0;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 10; i++) rd_chk(RA[i], RR[i]);
        rd_chk(ICC_DESC_PTR_OFS, 32'h0);
        $display("test reset values done");
        for (int i = 0; i < 10; i++) begin
            wr_reg(RA[i], 32'hffff_ffff);
            rd_chk(RA[i], R1[i]);
        end
        wr_reg(32'hfffc_0000, 32'hffff_ffff);
        rd_chk(32'hfffc_0000, 32'h0);
        $display("test access kinds done");
        wr_reg(ICC_PREVIEW_SIZE_OFS, 32'h03ff_03ff);
        settle();
        chk({21'h0, preview_height}, 32'd480);
        chk({21'h0, preview_width}, 32'd640);
        wr_reg(ICC_FORMAT_OFS, 32'h0);
        settle();
        chk({21'h0, preview_height}, 32'd1024);
        chk({21'h0, preview_width}, 32'd1024);
        wr_reg(ICC_PREVIEW_SIZE_OFS, 32'h0005_0009);
        settle();
        chk({21'h0, preview_height}, 32'd10);
        chk({21'h0, preview_width}, 32'd6);
        $display("test preview size done");
        for (int i = 0; i < 4; i++) begin
            wr_reg(ICC_PREVIEW_DECIM_OFS, {24'h0, DF[i]});
            settle();
            chk({24'h0, preview_decimation_ratio}, {24'h0, DR[i]});
            chk({31'h0, decimation_on}, {31'h0, DF[i] > 8'h10});
        end
        $display("test decimation done");
        wr_reg(ICC_PREVIEW_DESC_OFS, 32'h0000_1003);
        rd_chk(ICC_PREVIEW_DESC_OFS, 32'h0000_1000);
        @(posedge mclk);
        desc_load <= 1'b1;
        desc_next <= 32'h0000_2006;
        @(posedge mclk);
        desc_load <= 1'b0;
        rd_chk(ICC_PREVIEW_DESC_OFS, 32'h0000_2004);
        settle();
        chk(preview_descriptor_pointer, 32'h0000_2004);
        wr_reg(ICC_CODEC_BASE_OFS, 32'h8765_4321);
        rd_chk(ICC_CODEC_BASE_OFS, 32'h8765_4321);
        settle();
        chk(codec_base, 32'h8765_4321);
        $display("test addresses done");
        wr_reg(ICC_Y2R_B_OFS, 32'h0);
        wr_reg(ICC_Y2R_A_OFS, 32'h0000_0080);
        yuv_in <= {8'd100, 8'd50, 8'd30};
        settle();
        chk({8'h0, rgb_out}, 32'h0064_6464);
        wr_reg(ICC_Y2R_A_OFS, 32'h0);
        wr_reg(ICC_Y2R_B_OFS, 32'h0000_0100);
        settle();
        chk({8'h0, rgb_out}, 32'h0000_003c);
        yuv_in <= {8'd100, 8'd50, 8'd200};
        settle();
        chk({8'h0, rgb_out}, 32'h0000_00ff);
        wr_reg(ICC_Y2R_B_OFS, 32'h0000_1000);
        settle();
        chk({8'h0, rgb_out}, 32'h0080_8080);
        wr_reg(ICC_Y2R_B_OFS, 32'h0000_2000);
        settle();
        chk({8'h0, rgb_out}, 32'h0010_1000);
        wr_reg(ICC_Y2R_B_OFS, 32'h0000_4000);
        settle();
        chk({8'h0, rgb_out}, 32'h0000_1010);
        wr_reg(ICC_R2Y_B_OFS, 32'h0);
        wr_reg(ICC_R2Y_C_OFS, 32'h0);
        rgb_in <= {8'd200, 8'd77, 8'd255};
        for (int i = 0; i < 4; i++) begin
            wr_reg(ICC_R2Y_A_OFS, CA[i]);
            settle();
            chk({8'h0, yuv_out}, {8'h0, CY[i]});
        end
        wr_reg(ICC_R2Y_A_OFS, 32'h0);
        wr_reg(ICC_R2Y_B_OFS, 32'h0100_0000);
        settle();
        chk({8'h0, yuv_out}, 32'h0000_1000);
        $display("test colour matrices done");
        results();
    end
endmodule // tb_top

bind icc_config icc_config_chk u_chk (
    .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .desc_load(desc_load), .desc_next(desc_next),
    .preview_height(preview_height), .preview_width(preview_width),
    .preview_decimation_ratio(preview_decimation_ratio),
    .decimation_on(decimation_on),
    .preview_descriptor_pointer(preview_descriptor_pointer), .codec_base(codec_base)
);

`default_nettype wire
